// *** design/flash_pkg.sv ***
package flash_pkg;

   // ****************************************************************
   // clocking and serial clock rate
   // ****************************************************************
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned CLK_PERIOD_PS = 40_000;
   // ceiling on the serial clock, about 26.67 MHz
   localparam int unsigned SCK_MIN_PERIOD_PS = 37_500;
   localparam int unsigned SCK_MIN_CLKS = (SCK_MIN_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // input path lag; a half period must outlast it so read data is settled
   localparam int unsigned SYNC_STAGES = 3;
   localparam int unsigned HALF_CLKS = (SYNC_STAGES + 1 > SCK_MIN_CLKS) ? SYNC_STAGES + 1 : SCK_MIN_CLKS;
   localparam int unsigned BIT_CLKS = 2 * HALF_CLKS;

   // ****************************************************************
   // frame geometry
   // ****************************************************************
   localparam int unsigned ADDR_MSB = 23;
   localparam int unsigned CX_EXT = 7 + (ADDR_MSB + 1);
   localparam int unsigned CX_QUAD = 1 + (ADDR_MSB + 1) / 4;
   localparam logic [4:0] CMD_CLKS_EXT = 5'h08;
   localparam logic [4:0] CMD_CLKS_QUAD = 5'h02;
   localparam logic [4:0] ADDR_CLKS_EXT = 5'h18;
   localparam logic [4:0] ADDR_CLKS_QUAD = 5'h06;
   localparam logic [4:0] BYTE_CLKS_EXT = 5'h08;
   localparam logic [4:0] BYTE_CLKS_QUAD = 5'h02;
   // last clock position of a register write frame
   localparam int unsigned REGW_POS_EXT = 23;
   localparam int unsigned REGW_POS_QUAD = 5;
   localparam logic [8:0] REGW_MIN_BYTES = 9'((REGW_POS_EXT + 1 - 8) / 8);
   localparam logic [7:0] PAD_BYTE = 8'hFF;
   localparam logic [3:0] OE_ALL_OFF = 4'hF;
   localparam logic [3:0] OE_QUAD = 4'h0;
   localparam logic [3:0] OE_EXT = 4'hE;

   // ****************************************************************
   // commands and sequencer states
   // ****************************************************************
   typedef enum logic [1:0] {
      K_REG_RD = 2'h0,
      K_REG_WR = 2'h1,
      K_FAST_RD = 2'h2,
      K_PROG = 2'h3
   } kind_e;

   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_CMD = 7'h02,
      S_ADDR = 7'h04,
      S_DUMMY = 7'h08,
      S_WDATA = 7'h10,
      S_RDATA = 7'h20,
      S_GAP = 7'h40
   } seq_e;

endpackage

// *** design/byte_stream_if.sv ***
`timescale 1ns/1ps
interface byte_stream_if;
   logic in_valid;
   logic in_ready;
   logic [7:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [7:0] out_data;
   modport fill (output in_valid, output in_data, input in_ready);
   modport store (input in_valid, input in_data, output in_ready, output out_valid, output out_data,
                  input out_ready);
   modport drain (input out_valid, input out_data, output out_ready);
endinterface

// *** design/byte_buffer.sv ***
`timescale 1ns/1ps
module byte_buffer
   import flash_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   byte_stream_if.store bs
);

   typedef struct packed {
      logic v0;
      logic v1;
      logic [7:0] e0;
      logic [7:0] e1;
   } buf_s;

   buf_s s_reg;
   buf_s s_next;

   // head entry is what the reader sees; second entry absorbs a stall
   assign bs.out_valid = s_reg.v0;
   assign bs.out_data = s_reg.e0;
   assign bs.in_ready = !s_reg.v1;

   // pop first, then push into the first free slot
   always_comb begin
      s_next = s_reg;
      if (s_reg.v0 && bs.out_ready) begin
         s_next.e0 = s_reg.e1;
         s_next.v0 = s_reg.v1;
         s_next.v1 = 1'b0;
      end
      if (bs.in_valid && !s_reg.v1) begin
         if (s_next.v0) begin
            s_next.e1 = bs.in_data;
            s_next.v1 = 1'b1;
         end else begin
            s_next.e0 = bs.in_data;
            s_next.v0 = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_reg <= '0;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   chk_buf_order: assert property (@(posedge clk) disable iff (reset)
      s_reg.v1 |-> s_reg.v0) else $error("second entry held without a head");

endmodule

// *** design/flash_sequencer.sv ***
// What this block does
// - all register reads except lock register read
// - all register writes except lock register write
// - register write runs at least to clock 23 or 5
// - config register write sent low byte first
// - 24-bit address sent bit 23 down to 0
// - fast read in extended and quad protocol
// - page program in extended and quad protocol
// - extended command plus address is 8+24 clocks
// - quad command plus address is 2+24/4 clocks
// - serial clock kept below about 26.67 MHz
`timescale 1ns/1ps
module flash_sequencer
   import flash_pkg::*;
#(
   parameter logic [7:0] LOCK_RD_OP = 8'hD0,
   parameter logic [7:0] LOCK_WR_OP = 8'hD1
)(
   input wire logic CLK,
   input wire logic RESET,
   input wire logic CE,
   input wire logic CMD_VALID,
   output logic CMD_READY,
   input wire logic [1:0] CMD_KIND,
   input wire logic CMD_QUAD,
   input wire logic [7:0] CMD_OPCODE,
   input wire logic [23:0] CMD_ADDR,
   input wire logic [8:0] CMD_LEN,
   input wire logic [3:0] CMD_DUMMY,
   output logic CMD_REFUSED,
   output logic CMD_DONE,
   input wire logic WR_VALID,
   output logic WR_READY,
   input wire logic [7:0] WR_DATA,
   output logic RD_VALID,
   input wire logic RD_READY,
   output logic [7:0] RD_DATA,
   output logic SCK,
   output logic CS_N,
   input wire logic [3:0] IO_IN,
   output logic [3:0] IO_OUT,
   output logic [3:0] IO_OE_N
);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      seq_e st;
      kind_e kind;
      logic quad;
      logic [23:0] addr;
      logic [3:0] dummy;
      logic [2:0] div;
      logic [4:0] bits_left;
      logic [7:0] pos;
      logic [31:0] sr;
      logic [7:0] rx;
      logic [8:0] bytes_left;
      logic [8:0] real_left;
      logic need;
      logic push;
      logic [7:0] push_data;
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
      logic [3:0] io_f;
      logic sck;
      logic cs_n;
      logic [3:0] io_out;
      logic [3:0] io_oe_n;
      logic cmd_ready;
      logic wr_ready;
      logic refused;
      logic done;
   } seq_s;

   localparam seq_s RST_VAL = '{st: S_IDLE, kind: K_REG_RD, cs_n: 1'b1, io_oe_n: OE_ALL_OFF, default: '0};
   localparam logic [2:0] DIV_LAST = 3'(BIT_CLKS - 1);
   localparam logic [2:0] DIV_HALF = 3'(HALF_CLKS);

   seq_s s_reg;
   seq_s s_next;
   logic is_lock;

   byte_stream_if bs ();

   byte_buffer u_rx_buf (
      .clk(CLK),
      .reset(RESET),
      .ce(CE),
      .bs(bs.store)
   );

   function automatic logic [4:0] byte_clks(input logic quad);
      byte_clks = quad ? BYTE_CLKS_QUAD : BYTE_CLKS_EXT;
   endfunction

   function automatic logic is_write(input kind_e k);
      is_write = (k == K_REG_WR) || (k == K_PROG);
   endfunction

   // short register writes are stretched, zero-length reads become one byte
   function automatic logic [8:0] eff_len(input kind_e k, input logic [8:0] len);
      if (k == K_REG_WR && len < REGW_MIN_BYTES) begin
         eff_len = REGW_MIN_BYTES;
      end else if (len == 9'h000) begin
         eff_len = 9'h001;
      end else begin
         eff_len = len;
      end
   endfunction

   // ****************************************************************
   // outputs and buffer hookup
   // ****************************************************************
   assign CMD_READY = s_reg.cmd_ready;
   assign CMD_REFUSED = s_reg.refused;
   assign CMD_DONE = s_reg.done;
   assign WR_READY = s_reg.wr_ready;
   assign SCK = s_reg.sck;
   assign CS_N = s_reg.cs_n;
   assign IO_OUT = s_reg.io_out;
   assign IO_OE_N = s_reg.io_oe_n;
   assign bs.in_valid = s_reg.push;
   assign bs.in_data = s_reg.push_data;
   assign bs.out_ready = RD_READY;
   assign RD_VALID = bs.out_valid;
   assign RD_DATA = bs.out_data;

   // lock register access is the one register command turned away
   assign is_lock = (CMD_KIND == K_REG_RD && CMD_OPCODE == LOCK_RD_OP) ||
                    (CMD_KIND == K_REG_WR && CMD_OPCODE == LOCK_WR_OP);

   // ****************************************************************
   // sequencer
   // ****************************************************************
   // one serial clock per BIT_CLKS: drive at div 0, rise at half, sample and shift at the end
   always_comb begin
      logic [7:0] rx_new;
      logic stall;
      logic go_data;
      logic go_fetch;
      logic go_gap;
      rx_new = '0;
      stall = 1'b0;
      go_data = 1'b0;
      go_fetch = 1'b0;
      go_gap = 1'b0;
      s_next = s_reg;
      // pin inputs: a change counts once stages two and three agree
      s_next.s1 = IO_IN;
      s_next.s2 = s_reg.s1;
      s_next.s3 = s_reg.s2;
      if (s_reg.s2 == s_reg.s3) begin
         s_next.io_f = s_reg.s3;
      end
      s_next.refused = 1'b0;
      s_next.done = 1'b0;
      if (s_reg.push && bs.in_ready) begin
         s_next.push = 1'b0;
      end
      // bytes go out in the order given, so a config write leads with its low byte
      if (s_reg.wr_ready && WR_VALID) begin
         s_next.wr_ready = 1'b0;
         s_next.need = 1'b0;
         s_next.sr[31:24] = WR_DATA;
         s_next.real_left = s_reg.real_left - 9'h001;
      end
      // read bytes are forwarded in arrival order, low byte first for config reads
      rx_new = s_reg.quad ? {s_reg.rx[3:0], s_reg.io_f} : {s_reg.rx[6:0], s_reg.io_f[1]};
      unique case (s_reg.st)
         S_IDLE: begin
            s_next.cmd_ready = 1'b1;
            s_next.cs_n = 1'b1;
            s_next.sck = 1'b0;
            s_next.io_oe_n = OE_ALL_OFF;
            if (s_reg.cmd_ready && CMD_VALID) begin
               if (is_lock) begin
                  s_next.refused = 1'b1;
               end else begin
                  s_next.cmd_ready = 1'b0;
                  s_next.st = S_CMD;
                  s_next.cs_n = 1'b0;
                  s_next.kind = kind_e'(CMD_KIND);
                  s_next.quad = CMD_QUAD;
                  s_next.addr = CMD_ADDR;
                  s_next.dummy = CMD_DUMMY;
                  s_next.sr = {CMD_OPCODE, 24'h000000};
                  s_next.bits_left = CMD_QUAD ? CMD_CLKS_QUAD : CMD_CLKS_EXT;
                  s_next.div = 3'h0;
                  s_next.pos = 8'h00;
                  s_next.bytes_left = eff_len(kind_e'(CMD_KIND), CMD_LEN);
                  s_next.real_left = CMD_LEN;
               end
            end
         end
         S_CMD, S_ADDR, S_DUMMY, S_WDATA, S_RDATA: begin
            stall = (s_reg.st == S_WDATA && s_reg.need && s_reg.div == 3'h0) ||
                    (s_reg.st == S_RDATA && s_reg.div == DIV_LAST && s_reg.push && !bs.in_ready);
            if (!stall) begin
               s_next.div = (s_reg.div == DIV_LAST) ? 3'h0 : s_reg.div + 3'h1;
               if (s_reg.div == 3'h0) begin
                  s_next.sck = 1'b0;
                  if (s_reg.st == S_DUMMY || s_reg.st == S_RDATA) begin
                     s_next.io_oe_n = OE_ALL_OFF;
                  end else begin
                     s_next.io_oe_n = s_reg.quad ? OE_QUAD : OE_EXT;
                     s_next.io_out = s_reg.quad ? s_reg.sr[31:28] : {3'h0, s_reg.sr[31]};
                  end
               end
               if (s_reg.div == DIV_HALF) begin
                  s_next.sck = 1'b1;
               end
               if (s_reg.div == DIV_LAST) begin
                  s_next.rx = rx_new;
                  s_next.sr = s_reg.quad ? {s_reg.sr[27:0], 4'h0} : {s_reg.sr[30:0], 1'b0};
                  if (s_reg.pos != 8'hFF) begin
                     s_next.pos = s_reg.pos + 8'h01;
                  end
                  s_next.bits_left = s_reg.bits_left - 5'h01;
                  if (s_reg.bits_left == 5'h01) begin
                     if (s_reg.st == S_CMD && (s_reg.kind == K_FAST_RD || s_reg.kind == K_PROG)) begin
                        s_next.st = S_ADDR;
                        s_next.sr = {s_reg.addr, 8'h00};
                        s_next.bits_left = s_reg.quad ? ADDR_CLKS_QUAD : ADDR_CLKS_EXT;
                     end else if ((s_reg.st == S_CMD || s_reg.st == S_ADDR) && s_reg.dummy != 4'h0) begin
                        s_next.st = S_DUMMY;
                        s_next.bits_left = {1'b0, s_reg.dummy};
                     end else if (s_reg.st == S_CMD || s_reg.st == S_ADDR || s_reg.st == S_DUMMY) begin
                        go_data = 1'b1;
                     end else begin
                        if (s_reg.st == S_RDATA) begin
                           s_next.push = 1'b1;
                           s_next.push_data = rx_new;
                        end
                        s_next.bytes_left = s_reg.bytes_left - 9'h001;
                        if (s_reg.bytes_left == 9'h001) begin
                           go_gap = 1'b1;
                        end else begin
                           s_next.bits_left = byte_clks(s_reg.quad);
                           go_fetch = (s_reg.st == S_WDATA);
                        end
                     end
                  end
               end
            end
            if (go_data) begin
               s_next.bits_left = byte_clks(s_reg.quad);
               if (is_write(s_reg.kind)) begin
                  s_next.st = S_WDATA;
                  go_fetch = 1'b1;
               end else begin
                  s_next.st = S_RDATA;
               end
            end
            if (go_fetch) begin
               if (s_reg.real_left != 9'h000) begin
                  s_next.wr_ready = 1'b1;
                  s_next.need = 1'b1;
               end else begin
                  s_next.sr[31:24] = PAD_BYTE;
               end
            end
            // the last high phase keeps its full length, so the clock is not cut here
            if (go_gap) begin
               s_next.st = S_GAP;
               s_next.io_oe_n = OE_ALL_OFF;
            end
         end
         S_GAP: begin
            // clock drops first, then select rises with the clock already low
            if (s_reg.div == 3'h0) begin
               s_next.sck = 1'b0;
            end
            if (!s_reg.sck) begin
               s_next.cs_n = 1'b1;
            end
            if (s_reg.div == DIV_LAST) begin
               s_next.div = 3'h0;
               s_next.st = S_IDLE;
               s_next.done = 1'b1;
            end else begin
               s_next.div = s_reg.div + 3'h1;
            end
         end
         default: begin
            s_next = RST_VAL;
         end
      endcase
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         s_reg <= RST_VAL;
      end else if (CE) begin
         s_reg <= s_next;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   sequence lock_rd_req;
      CE && s_reg.cmd_ready && CMD_VALID && CMD_KIND == K_REG_RD && CMD_OPCODE == LOCK_RD_OP;
   endsequence

   sequence lock_wr_req;
      CE && s_reg.cmd_ready && CMD_VALID && CMD_KIND == K_REG_WR && CMD_OPCODE == LOCK_WR_OP;
   endsequence

   sequence turned_away;
      CMD_REFUSED && CS_N && s_reg.st == S_IDLE;
   endsequence

   chk_lock_read_refused: assert property (lock_rd_req |=> turned_away)
      else $error("lock register read was not refused");
   chk_lock_write_refused: assert property (lock_wr_req |=> turned_away)
      else $error("lock register write was not refused");
   chk_regw_frame_len: assert property ($rose(CS_N) && s_reg.kind == K_REG_WR |->
      s_reg.pos > (s_reg.quad ? 8'(REGW_POS_QUAD) : 8'(REGW_POS_EXT)))
      else $error("register write frame too short");
   chk_addr_load_order: assert property (s_reg.st == S_ADDR && $past(s_reg.st) != S_ADDR |->
      s_reg.sr[31:8] == s_reg.addr) else $error("address not loaded top bit first");
   chk_ext_cx_count: assert property (CE && s_reg.st == S_ADDR && s_next.st != S_ADDR && !s_reg.quad |->
      s_next.pos == 8'(CX_EXT + 1)) else $error("extended command plus address length wrong");
   chk_quad_cx_count: assert property (CE && s_reg.st == S_ADDR && s_next.st != S_ADDR && s_reg.quad |->
      s_next.pos == 8'(CX_QUAD + 1)) else $error("quad command plus address length wrong");
   chk_sck_high_min: assert property ($rose(SCK) |=> SCK [*3])
      else $error("serial clock high phase too short");
   chk_sck_low_min: assert property ($fell(SCK) |=> !SCK [*3])
      else $error("serial clock low phase too short");
   chk_read_released: assert property (s_reg.st == S_RDATA && s_reg.div != 3'h0 |-> IO_OE_N == OE_ALL_OFF)
      else $error("data lines driven during read");
   chk_prog_drives: assert property (s_reg.st == S_WDATA && !s_reg.need && s_reg.div != 3'h0 |->
      IO_OE_N == (s_reg.quad ? OE_QUAD : OE_EXT)) else $error("data lines not driven during write");
   chk_cs_framing: assert property (s_reg.st inside {S_CMD, S_ADDR, S_DUMMY, S_WDATA, S_RDATA} |-> !CS_N)
      else $error("chip select high inside a transaction");

endmodule

// *** tb/flash_model.sv ***
`timescale 1ns/1ps
// ************************************************************
// behavioural serial flash at the far side of the link
// ************************************************************
module flash_model (
   input wire logic sck,
   input wire logic cs_n,
   input wire logic [3:0] io_out,
   input wire logic [3:0] io_oe_n,
   output logic [3:0] io_in,
   input wire logic quad,
   input wire logic [7:0] rd_start,
   input wire logic [7:0] rd_seed
);
   logic [3:0] cap[$];
   logic [3:0] drv = 4'hA;
   logic [7:0] rb;
   int clk_n = 0;
   int frames = 0;
   int b;
   realtime last_rise = 0.0;
   realtime min_per = 1.0e9;

   // wire level: the device wins where it drives, else the flash
   assign io_in = (io_oe_n & drv) | (~io_oe_n & io_out);

   // a chip select fall opens a new frame
   always @(negedge cs_n) begin
      clk_n = 0;
      cap.delete();
      frames++;
   end

   // lines are captured on each serial clock rise, shortest period kept
   always @(posedge sck) begin
      if (!cs_n) begin
         cap.push_back(io_in);
         if (clk_n > 0 && $realtime - last_rise < min_per)
            min_per = $realtime - last_rise;
         last_rise = $realtime;
         clk_n++;
      end
   end

   // data moves after each fall; idle lines flip so a stale copy never passes
   always @(negedge sck or posedge cs_n) begin
      drv = ~drv;
      if (!cs_n && clk_n >= rd_start) begin
         b = clk_n - rd_start;
         rb = rd_seed + 8'(b / (quad ? 2 : 8)) * 8'h3B;
         if (quad)
            drv = (b % 2 == 0) ? rb[7:4] : rb[3:0];
         else
            drv[1] = rb[7 - b % 8];
      end
   end
endmodule

// *** tb/serial_flash_command_sequencer_tb.sv ***
`timescale 1ns/1ps
module serial_flash_command_sequencer_tb;
   import flash_pkg::*;
   logic clk = 1'b0, reset = 1'b1, ce = 1'b0, cmd_valid = 1'b0, cmd_quad = 1'b0, wr_valid = 1'b0, rd_ready = 1'b0;
   logic [1:0] cmd_kind = 2'h0;
   logic [7:0] cmd_opcode = 8'h00, wr_data = 8'h00, rd_start = 8'h00, rd_seed = 8'h00, rd_data;
   logic [23:0] cmd_addr = 24'h000000;
   logic [8:0] cmd_len = 9'h000;
   logic [3:0] cmd_dummy = 4'h0, io_in, io_out, io_oe_n;
   logic cmd_ready, cmd_refused, cmd_done, wr_ready, rd_valid, sck, cs_n;
   logic [31:0] seed = 32'h574E278E;
   logic [7:0] wq[$];
   int failures = 0, compares = 0, stall = 0;

   // 25 MHz system clock
   always #20 clk = ~clk;

   flash_sequencer #(.LOCK_RD_OP(8'hD0), .LOCK_WR_OP(8'hD1)) u_dut (.CLK(clk), .RESET(reset), .CE(ce),
      .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_KIND(cmd_kind), .CMD_QUAD(cmd_quad),
      .CMD_OPCODE(cmd_opcode), .CMD_ADDR(cmd_addr), .CMD_LEN(cmd_len), .CMD_DUMMY(cmd_dummy),
      .CMD_REFUSED(cmd_refused), .CMD_DONE(cmd_done), .WR_VALID(wr_valid), .WR_READY(wr_ready),
      .WR_DATA(wr_data), .RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_DATA(rd_data), .SCK(sck),
      .CS_N(cs_n), .IO_IN(io_in), .IO_OUT(io_out), .IO_OE_N(io_oe_n));

   flash_model u_mdl (.sck(sck), .cs_n(cs_n), .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in),
      .quad(cmd_quad), .rd_start(rd_start), .rd_seed(rd_seed));

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // value carried by n captured clocks from position p, msb first
   function automatic logic [31:0] wire_val(input int p, input int n, input logic q);
      logic [31:0] v = 32'h0;
      for (int i = 0; i < n; i++) begin
         v = q ? {v[27:0], u_mdl.cap[p + i]} : {v[30:0], u_mdl.cap[p + i][0]};
      end
      return v;
   endfunction

   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task results;
      if (failures == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task bound(input int n, input int lim);
      if (n >= lim) begin
         failures++;
         results();
      end
   endtask

   // clock enable drops about one cycle in eight to stretch every phase
   task tick;
      @(negedge clk);
      ce = (3'(rnd()) != 3'h0);
   endtask

   // ************************************************************
   // one transaction: issue, feed, drain, then judge the frame
   // ************************************************************
   task run(input logic [1:0] k, input logic q, input logic [7:0] op, input int len, input int dmy);
      int nb, nr, nw, cw, pd, clks, n, r, cnt, fr;
      logic refuse, seen;
      nb = (len == 0) ? 1 : len;
      // only the stated length is fetched; a zero length write sends pad only
      nw = k[0] ? len : 0;
      nr = k[0] ? 0 : nb;
      if (k == K_REG_WR && nb < 2)
         nb = 2;
      cw = q ? 2 : 8;
      pd = cw + (k[1] ? (q ? 6 : 24) : 0) + dmy;
      clks = pd + nb * cw;
      refuse = (k == K_REG_RD && op == 8'hD0) || (k == K_REG_WR && op == 8'hD1);
      wq.delete();
      for (int i = 0; i < nw; i++)
         wq.push_back(8'(rnd()));
      fr = u_mdl.frames;
      tick;
      cmd_valid = 1'b1;
      cmd_kind = k;
      cmd_quad = q;
      cmd_opcode = op;
      cmd_addr = 24'(rnd());
      cmd_len = 9'(len);
      cmd_dummy = 4'(dmy);
      rd_start = 8'(pd);
      rd_seed = 8'(rnd());
      n = 0;
      while (n < 2000) begin
         @(posedge clk);
         if (ce && cmd_ready)
            break;
         tick;
         n++;
      end
      bound(n, 2000);
      tick;
      cmd_valid = 1'b0;
      @(posedge clk);
      check(cmd_refused, refuse);
      if (refuse) begin
         repeat (20) tick;
         check(u_mdl.frames, fr);
         return;
      end
      n = 0;
      r = 0;
      cnt = 0;
      seen = 1'b0;
      // write bytes offered in order, reader stalls at random
      while (cnt < 20000) begin
         tick;
         wr_valid = (n < nw);
         wr_data = (n < nw) ? wq[n] : 8'h00;
         rd_ready = (cnt >= stall) && (3'(rnd()) > 3'h1);
         @(posedge clk);
         if (ce && wr_valid && wr_ready)
            n++;
         if (ce && rd_valid && rd_ready) begin
            check(rd_data, 8'(rd_seed + 8'(r) * 8'h3B));
            r++;
         end
         if (cmd_done)
            seen = 1'b1;
         if (seen && r >= nr)
            break;
         cnt++;
      end
      bound(cnt, 20000);
      check(n, nw);
      check(u_mdl.frames - fr, 1);
      check(u_mdl.cap.size(), clks);
      check(wire_val(0, cw, q), op);
      if (k[1])
         check(wire_val(cw, q ? 6 : 24, q), cmd_addr);
      for (int i = 0; i < (k[0] ? nb : 0); i++)
         check(wire_val(pd + i * cw, cw, q), (i < nw) ? wq[i] : PAD_BYTE);
      check(u_mdl.min_per >= 37.5, 1'b1);
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      logic [1:0] k;
      repeat (20) @(negedge clk);
      reset = 1'b0;
      ce = 1'b1;
      // every kind in both protocols
      for (int i = 0; i < 8; i++)
         run(2'(i / 2), 1'(i), 8'h05 + 8'(i), 1 + i / 2, i[1] ? 0 : 8);
      // short register writes padded out to the last position
      run(K_REG_WR, 1'b0, 8'hB1, 0, 0);
      run(K_REG_WR, 1'b1, 8'hB1, 1, 0);
      // lock opcodes refused; same opcode on a memory kind goes out
      run(K_REG_RD, 1'b0, 8'hD0, 1, 0);
      run(K_REG_WR, 1'b1, 8'hD1, 2, 0);
      run(K_FAST_RD, 1'b0, 8'hD0, 1, 8);
      // long read while the reader stalls, so the buffer fills
      stall = 400;
      run(K_FAST_RD, 1'b1, 8'h6B, 9, 8);
      stall = 0;
      // random mix
      repeat (12) begin
         k = 2'(rnd());
         run(k, 1'(rnd()), 8'(rnd()), int'(rnd() % 6), k[0] ? 0 : int'(rnd() % 9));
      end
      results();
   end
endmodule
